// ---- shared/psc_defs.vh ----
// Constants for the portal panel controller: register map, fields, resets, timing.
// Included by the panel controller only; holds definitions only.
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

`define PSC_CLK_NS           100
`define PSC_SEC_NS           1000000000
`define PSC_ANIM_STEPS_PER_S 8

`define PSC_OFS_CFG          6'h00
`define PSC_OFS_NODE         6'h04
`define PSC_OFS_TIMES        6'h08
`define PSC_OFS_HOST_TO      6'h0C
`define PSC_OFS_TEST         6'h10
`define PSC_OFS_FLAGS        6'h14
`define PSC_OFS_CMD          6'h18
`define PSC_OFS_IRQ_ST       6'h1C
`define PSC_OFS_IRQ_MASK     6'h20
`define PSC_OFS_STATUS       6'h24

`define PSC_CFG_GATE         0
`define PSC_CFG_PEX          1
`define PSC_CFG_PPS          2
`define PSC_CFG_PFB          3

`define PSC_RST_NODE         7'h01
`define PSC_RST_ACK_TO_S     8'h1E
`define PSC_RST_EXTRA_S      8'h00
`define PSC_RST_HOST_TO_S    16'h012C
`define PSC_MOTION_BASE_S    16'h0005
`define PSC_PWR_OFF_S        16'h000A

`define PSC_OP_DISPLAY       4'h1
`define PSC_OP_CYC_ACTIVE    4'h2
`define PSC_OP_CYC_COMPUTER  4'h3
`define PSC_OP_CYC_MODEM     4'h4
`define PSC_OP_FIELD_OFF     4'h5
`define PSC_OP_FIELD_ON      4'h6
`define PSC_OP_RESET_FLAGS   4'h7

`define PSC_REPLY_OK         8'h01
`define PSC_REPLY_DONE       8'h00
`define PSC_REPLY_NONE       8'hFF

`define PSC_IRQ_TEST         0
`define PSC_IRQ_SEND         1
`define PSC_IRQ_PWR_DONE     2
`define PSC_IRQ_CMD_ACK      3
`define PSC_IRQ_DISP_TO      4
`define PSC_IRQ_W            5

`endif

// ---- rtl/psc_sync.v ----
// Three-stage pin synchroniser; output changes once stages two and three agree.
// Assumes asynchronous level inputs and one clock.
`timescale 1ns/1ns
module psc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] pin,
  output wire [W-1:0] level
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] out_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!rst_n) begin
          s1_r[i]  <= 1'b0;
          s2_r[i]  <= 1'b0;
          s3_r[i]  <= 1'b0;
          out_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pin[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            out_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
  assign level = out_r;
endmodule // psc_sync

// ---- rtl/psc_sec_timer.v ----
// Seconds countdown timer; restartable, counts a shared one-second tick.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
module psc_sec_timer #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         tick,
  input  wire         start,
  input  wire [W-1:0] load,
  output wire         busy,
  output wire         done
);
  reg [W-1:0] count_r;
  reg         done_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      count_r <= {W{1'b0}};
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        count_r <= load;
      end else if (tick && (count_r != {W{1'b0}})) begin
        count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
        if (count_r == {{(W-1){1'b0}}, 1'b1}) begin
          done_r <= 1'b1;
        end
      end
    end
  end
  assign busy = (count_r != {W{1'b0}});
  assign done = done_r;
endmodule // psc_sec_timer

// ---- rtl/psc_panel_ctrl.v ----
// Portal panel controller: display, buttons, motion gating, field LED, power cycling.
// Assumes one 10 MHz clock, synchronous reset and an Avalon-MM master.
`timescale 1ns/1ns
`include "psc_defs.vh"
module psc_panel_ctrl #(
  parameter TICK_CYC = `PSC_SEC_NS / `PSC_CLK_NS,
  parameter ANIM_CYC = TICK_CYC / `PSC_ANIM_STEPS_PER_S
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        btn_test_pin,
  input  wire        btn_send_pin,
  input  wire        motion_pin,
  input  wire        exciter_fb_pin,
  input  wire        passive_fb_pin,
  input  wire        exciter_low_pin,
  output reg  [6:0]  seg_tens_r,
  output reg  [6:0]  seg_ones_r,
  output reg         field_led_r,
  output reg         exciter_en_r,
  output reg         passive_en_r,
  output reg         exciter_field_on_r,
  output reg  [2:0]  pwr_off_r,
  output reg         irq_r
);
  localparam integer TICK_LAST_I = TICK_CYC - 1;
  localparam integer ANIM_LAST_I = ANIM_CYC - 1;
  localparam [23:0] TICK_LAST = TICK_LAST_I[23:0];
  localparam [23:0] ANIM_LAST = ANIM_LAST_I[23:0];
  localparam [1:0] DM_IDLE  = 2'h0;
  localparam [1:0] DM_ACK   = 2'h1;
  localparam [1:0] DM_SHOW  = 2'h2;
  localparam [1:0] DM_FLASH = 2'h3;

  function [6:0] hex_seg;
    input [3:0] v;
    begin
      case (v)
        4'h0: hex_seg = 7'h3F;
        4'h1: hex_seg = 7'h06;
        4'h2: hex_seg = 7'h5B;
        4'h3: hex_seg = 7'h4F;
        4'h4: hex_seg = 7'h66;
        4'h5: hex_seg = 7'h6D;
        4'h6: hex_seg = 7'h7D;
        4'h7: hex_seg = 7'h07;
        4'h8: hex_seg = 7'h7F;
        4'h9: hex_seg = 7'h6F;
        4'hA: hex_seg = 7'h77;
        4'hB: hex_seg = 7'h7C;
        4'hC: hex_seg = 7'h39;
        4'hD: hex_seg = 7'h5E;
        4'hE: hex_seg = 7'h79;
        default: hex_seg = 7'h71;
      endcase
    end
  endfunction

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Pin synchronisers and press edges
  wire [5:0] pins_s;
  psc_sync #(.W(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   ({exciter_low_pin, passive_fb_pin, exciter_fb_pin,
             motion_pin, btn_send_pin, btn_test_pin}),
    .level (pins_s)
  );
  wire test_s    = pins_s[0];
  wire send_s    = pins_s[1];
  wire motion_s  = pins_s[2];
  wire exc_fb_s  = pins_s[3];
  wire pas_fb_s  = pins_s[4];
  wire exc_low_s = pins_s[5];

  reg        test_d_r;
  reg        send_d_r;
  wire       test_press = test_s & ~test_d_r;
  wire       send_press = send_s & ~send_d_r;

  // Tick prescalers
  reg [23:0] tick_cnt_r;
  reg [23:0] anim_cnt_r;
  reg        tick_r;
  reg        anim_r;
  reg [2:0]  anim_step_r;
  reg        boot_r;
  wire       blink_on = anim_step_r[2];

  always @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_r  <= 24'h000000;
      anim_cnt_r  <= 24'h000000;
      tick_r      <= 1'b0;
      anim_r      <= 1'b0;
      anim_step_r <= 3'h0;
      boot_r      <= 1'b1;
      test_d_r    <= 1'b0;
      send_d_r    <= 1'b0;
    end else begin
      boot_r   <= 1'b0;
      test_d_r <= test_s;
      send_d_r <= send_s;
      tick_r   <= (tick_cnt_r == TICK_LAST);
      anim_r   <= (anim_cnt_r == ANIM_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? 24'h000000 : tick_cnt_r + 24'h000001;
      anim_cnt_r <= (anim_cnt_r == ANIM_LAST) ? 24'h000000 : anim_cnt_r + 24'h000001;
      if (anim_r) begin
        anim_step_r <= anim_step_r + 3'h1;
      end
    end
  end

  // Register file
  reg [3:0]  cfg_r;
  reg [6:0]  node_r;
  reg [7:0]  ack_to_r;
  reg [7:0]  extra_r;
  reg [15:0] host_to_r;
  reg [7:0]  limit_r;
  reg [7:0]  result_r;
  reg [1:0]  flags_r;
  reg [7:0]  reply_r;
  reg [`PSC_IRQ_W-1:0] irq_st_r;
  reg [`PSC_IRQ_W-1:0] irq_mask_r;
  reg        cmd_go_r;
  reg [3:0]  cmd_op_r;
  reg [8:0]  cmd_arg_r;
  reg [1:0]  flags_nxt;
  reg [`PSC_IRQ_W-1:0] irq_nxt;
  reg [31:0] wv;
  reg [31:0] rd_nxt;

  wire wr_go = avs_write & ~avs_waitrequest;
  wire pwr_done;
  wire pwr_busy;
  wire disp_to;
  reg  [1:0] disp_mode_r;
  reg  [7:0] code_r;
  reg        test_mode_r;
  wire [`PSC_IRQ_W-1:0] irq_evt = {disp_to, cmd_go_r, pwr_done, send_press, test_press};

  always @* begin
    wv = be_merge(32'h00000000, avs_writedata, avs_byteenable);
    flags_nxt = flags_r;
    irq_nxt = irq_st_r;
    if (wr_go && avs_address == `PSC_OFS_FLAGS && avs_byteenable[0]) begin
      flags_nxt = flags_r & avs_writedata[1:0];
    end
    if (cmd_go_r && cmd_op_r == `PSC_OP_RESET_FLAGS) begin
      flags_nxt = 2'h0;
    end
    flags_nxt = flags_nxt | {send_press, test_press};
    if (wr_go && avs_address == `PSC_OFS_IRQ_ST) begin
      irq_nxt = irq_st_r & ~wv[`PSC_IRQ_W-1:0];
    end
    irq_nxt = irq_nxt | irq_evt;
    case (avs_address)
      `PSC_OFS_CFG:      rd_nxt = {28'h0000000, cfg_r};
      `PSC_OFS_NODE:     rd_nxt = {25'h0, node_r};
      `PSC_OFS_TIMES:    rd_nxt = {16'h0000, extra_r, ack_to_r};
      `PSC_OFS_HOST_TO:  rd_nxt = {16'h0000, host_to_r};
      `PSC_OFS_TEST:     rd_nxt = {16'h0000, result_r, limit_r};
      `PSC_OFS_FLAGS:    rd_nxt = {30'h0, flags_r};
      `PSC_OFS_CMD:      rd_nxt = {23'h0, pwr_busy, reply_r};
      `PSC_OFS_IRQ_ST:   rd_nxt = {27'h0, irq_st_r};
      `PSC_OFS_IRQ_MASK: rd_nxt = {27'h0, irq_mask_r};
      `PSC_OFS_STATUS:   rd_nxt = {24'h000000, disp_mode_r, pas_fb_s, exc_fb_s,
                                   motion_s, exciter_field_on_r, field_led_r, pwr_busy};
      default:           rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      cfg_r      <= 4'h0;
      node_r     <= `PSC_RST_NODE;
      ack_to_r   <= `PSC_RST_ACK_TO_S;
      extra_r    <= `PSC_RST_EXTRA_S;
      host_to_r  <= `PSC_RST_HOST_TO_S;
      limit_r    <= 8'h00;
      result_r   <= 8'h00;
      flags_r    <= 2'h0;
      reply_r    <= `PSC_REPLY_NONE;
      irq_st_r   <= {`PSC_IRQ_W{1'b0}};
      irq_mask_r <= {`PSC_IRQ_W{1'b0}};
      irq_r      <= 1'b0;
      cmd_go_r   <= 1'b0;
      cmd_op_r   <= 4'h0;
      cmd_arg_r  <= 9'h000;
    end else begin
      cmd_go_r <= 1'b0;
      flags_r  <= flags_nxt;
      irq_st_r <= irq_nxt;
      irq_r    <= |(irq_nxt & irq_mask_r);
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_nxt;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (test_mode_r && send_press) begin
        result_r <= code_r;
      end
      if (cmd_go_r) begin
        reply_r <= `PSC_REPLY_OK;
      end
      if (pwr_done) begin
        reply_r <= `PSC_REPLY_DONE;
      end
      if (wr_go) begin
        case (avs_address)
          `PSC_OFS_CFG: begin
            if (avs_byteenable[0]) begin
              cfg_r <= avs_writedata[3:0];
            end
          end
          `PSC_OFS_NODE: begin
            if (avs_byteenable[0]) begin
              node_r <= avs_writedata[6:0];
            end
          end
          `PSC_OFS_TIMES: begin
            if (avs_byteenable[0]) begin
              ack_to_r <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
              extra_r <= avs_writedata[15:8];
            end
          end
          `PSC_OFS_HOST_TO: begin
            if (avs_byteenable[0]) begin
              host_to_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
              host_to_r[15:8] <= avs_writedata[15:8];
            end
          end
          `PSC_OFS_TEST: begin
            if (avs_byteenable[0]) begin
              limit_r <= avs_writedata[7:0];
            end
          end
          `PSC_OFS_CMD: begin
            if (avs_byteenable == 4'hF && avs_writedata[14:8] == node_r) begin
              cmd_go_r  <= 1'b1;
              cmd_op_r  <= avs_writedata[3:0];
              cmd_arg_r <= avs_writedata[24:16];
            end
          end
          `PSC_OFS_IRQ_MASK: begin
            if (avs_byteenable[0]) begin
              irq_mask_r <= avs_writedata[`PSC_IRQ_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Display state and timers
  wire host_done;
  wire ack_done;
  wire ack_start = (test_press | send_press) & (limit_r == 8'h00);
  reg  [7:0] disp_val_r;
  reg        disp_blink_r;

  psc_sec_timer #(.W(16)) u_host_to (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_r),
    .start (boot_r),
    .load  (host_to_r),
    .busy  (),
    .done  (host_done)
  );
  psc_sec_timer #(.W(16)) u_ack_to (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_r),
    .start (ack_start),
    .load  ({8'h00, ack_to_r}),
    .busy  (),
    .done  (ack_done)
  );
  assign disp_to = (host_done && disp_mode_r == DM_IDLE) ||
                   (ack_done && disp_mode_r == DM_ACK);

  always @(posedge clk) begin
    if (!rst_n) begin
      disp_mode_r  <= DM_IDLE;
      disp_val_r   <= 8'h00;
      disp_blink_r <= 1'b0;
      code_r       <= 8'h00;
      test_mode_r  <= 1'b0;
    end else begin
      if (cmd_go_r && cmd_op_r == `PSC_OP_DISPLAY) begin
        disp_mode_r  <= DM_SHOW;
        disp_val_r   <= cmd_arg_r[7:0];
        disp_blink_r <= cmd_arg_r[8];
        test_mode_r  <= 1'b0;
      end else if (test_press && limit_r != 8'h00) begin
        disp_mode_r  <= DM_SHOW;
        disp_blink_r <= 1'b0;
        test_mode_r  <= 1'b1;
        if (!test_mode_r || code_r >= limit_r) begin
          code_r     <= 8'h00;
          disp_val_r <= 8'h00;
        end else begin
          code_r     <= code_r + 8'h01;
          disp_val_r <= code_r + 8'h01;
        end
      end else if (ack_start) begin
        disp_mode_r <= DM_ACK;
        test_mode_r <= 1'b0;
      end else if (disp_to) begin
        disp_mode_r <= DM_FLASH;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      seg_tens_r <= 7'h00;
      seg_ones_r <= 7'h00;
    end else begin
      case (disp_mode_r)
        DM_IDLE, DM_ACK: begin
          seg_tens_r <= 7'h01 << ((anim_step_r >= 3'h6) ? 3'h0 : anim_step_r);
          seg_ones_r <= 7'h01 << ((anim_step_r >= 3'h6) ? 3'h0 : anim_step_r);
        end
        DM_SHOW: begin
          seg_tens_r <= (disp_blink_r && !blink_on) ? 7'h00 : hex_seg(disp_val_r[7:4]);
          seg_ones_r <= (disp_blink_r && !blink_on) ? 7'h00 : hex_seg(disp_val_r[3:0]);
        end
        default: begin
          seg_tens_r <= blink_on ? hex_seg(4'hF) : 7'h00;
          seg_ones_r <= blink_on ? hex_seg(4'hF) : 7'h00;
        end
      endcase
    end
  end

  // Motion gating and field LED
  wire motion_busy;
  wire gate_on = cfg_r[`PSC_CFG_GATE];
  wire exciter_present = cfg_r[`PSC_CFG_PEX];
  wire passive_reader_present = cfg_r[`PSC_CFG_PPS];
  wire feedback_required = cfg_r[`PSC_CFG_PFB];
  psc_sec_timer #(.W(16)) u_motion (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_r),
    .start (motion_s),
    .load  (`PSC_MOTION_BASE_S + {8'h00, extra_r}),
    .busy  (motion_busy),
    .done  ()
  );
  wire trig = ~gate_on | motion_s | motion_busy;
  reg  led_base;
  always @* begin
    case ({exciter_present, passive_reader_present, feedback_required})
      3'b100, 3'b101: led_base = exc_fb_s;
      3'b011:         led_base = pas_fb_s;
      3'b110:         led_base = exc_fb_s;
      3'b111:         led_base = exc_fb_s & pas_fb_s;
      default:        led_base = 1'b1;
    endcase
  end
  wire led_blink = feedback_required & exciter_present & exc_low_s;

  always @(posedge clk) begin
    if (!rst_n) begin
      field_led_r  <= 1'b0;
      exciter_en_r <= 1'b0;
      passive_en_r <= 1'b0;
    end else begin
      exciter_en_r <= trig;
      passive_en_r <= trig;
      field_led_r  <= trig & led_base & (~led_blink | blink_on);
    end
  end

  // Power cycling and exciter field
  wire pwr_cmd = cmd_go_r && (cmd_op_r == `PSC_OP_CYC_ACTIVE ||
                 cmd_op_r == `PSC_OP_CYC_COMPUTER || cmd_op_r == `PSC_OP_CYC_MODEM);
  wire pwr_start = pwr_cmd & ~pwr_busy;
  psc_sec_timer #(.W(16)) u_pwr (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_r),
    .start (pwr_start),
    .load  (`PSC_PWR_OFF_S),
    .busy  (pwr_busy),
    .done  (pwr_done)
  );
  always @(posedge clk) begin
    if (!rst_n) begin
      pwr_off_r          <= 3'h0;
      exciter_field_on_r <= 1'b1;
    end else begin
      if (pwr_start) begin
        case (cmd_op_r)
          `PSC_OP_CYC_ACTIVE:   pwr_off_r <= 3'h1;
          `PSC_OP_CYC_COMPUTER: pwr_off_r <= 3'h2;
          default:              pwr_off_r <= 3'h4;
        endcase
      end else if (pwr_done) begin
        pwr_off_r <= 3'h0;
      end
      if (cmd_go_r && cmd_op_r == `PSC_OP_FIELD_OFF) begin
        exciter_field_on_r <= 1'b0;
      end else if (cmd_go_r && cmd_op_r == `PSC_OP_FIELD_ON) begin
        exciter_field_on_r <= 1'b1;
      end
    end
  end
endmodule // psc_panel_ctrl

// ---- tb/psc_panel_ctrl_sva.sv ----
// Port checker for the portal panel controller.
// Bound to the design top from the bench; sees only its ports.
`timescale 1ns/1ns
module psc_panel_ctrl_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        motion_pin,
  input wire        field_led_r,
  input wire        exciter_en_r,
  input wire        passive_en_r,
  input wire [2:0]  pwr_off_r,
  input wire        irq_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("access not answered");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_wait_idle;
    !(avs_read || avs_write) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without access");
  property p_rdata_hold;
    avs_waitrequest |-> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_en_pair;
    exciter_en_r == passive_en_r;
  endproperty
  a_en_pair: assert property (p_en_pair) else $error("reader enables differ");
  property p_motion_en;
    motion_pin [*8] |-> exciter_en_r && passive_en_r;
  endproperty
  a_motion_en: assert property (p_motion_en) else $error("motion without enables");
  property p_led_en;
    !exciter_en_r [*2] |-> !field_led_r;
  endproperty
  a_led_en: assert property (p_led_en) else $error("field led without enable");
  property p_pwr_hold;
    $rose(pwr_off_r[0]) |=> pwr_off_r[0] [*8];
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power back too soon");
  c_irq: cover property ($rose(irq_r));
  c_pwr: cover property ($rose(pwr_off_r[2]));
  c_led: cover property ($fell(field_led_r));
endmodule // psc_panel_ctrl_sva

// ---- tb/psc_panel_model.sv ----
// Panel model: push buttons, motion sensor and reader feedback lines.
// Driven by the bench through its tasks; pins change just after clk edges.
`timescale 1ns/1ns
module psc_panel_model (
  input wire clk,
  output reg btn_test,
  output reg btn_send,
  output reg motion,
  output reg exc_fb,
  output reg pas_fb,
  output reg exc_low
);
  initial begin
    {btn_test, btn_send, motion, exc_fb, pas_fb, exc_low} = 6'h00;
  end
  // Press held long enough to pass the pin synchroniser
  task press(input integer b);
    begin
      @(posedge clk);
      if (b == 0) btn_test <= 1'b1;
      else btn_send <= 1'b1;
      repeat (8) @(posedge clk);
      btn_test <= 1'b0;
      btn_send <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task drive(input m, input e, input p, input l);
    begin
      @(posedge clk);
      motion  <= m;
      exc_fb  <= e;
      pas_fb  <= p;
      exc_low <= l;
    end
  endtask
endmodule // psc_panel_model

// ---- tb/tb_portal_panel_controller.sv ----
// Bench for the portal panel controller: Avalon-MM master plus panel model.
// Assumes shortened tick of 16 cycles and animation step of 2 cycles.
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_portal_panel_controller;
  reg         clk, rst_n, avs_read, avs_write;
  reg  [5:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  reg  [3:0]  avs_byteenable;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, bt, bs, mo, ef, pf, el;
  wire [6:0]  seg_tens_r, seg_ones_r;
  wire        field_led_r, exciter_en_r, passive_en_r, exciter_field_on_r, irq_r;
  wire [2:0]  pwr_off_r;
  integer     n_fail, samples_checked, i, j;
  reg         hi, lo, blk;
  psc_panel_model i_pnl (.clk(clk), .btn_test(bt), .btn_send(bs), .motion(mo),
    .exc_fb(ef), .pas_fb(pf), .exc_low(el));
  psc_panel_ctrl #(.TICK_CYC(16), .ANIM_CYC(2)) i_dut (.clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .btn_test_pin(bt), .btn_send_pin(bs), .motion_pin(mo),
    .exciter_fb_pin(ef), .passive_fb_pin(pf), .exciter_low_pin(el), .seg_tens_r,
    .seg_ones_r, .field_led_r, .exciter_en_r, .passive_en_r, .exciter_field_on_r,
    .pwr_off_r, .irq_r);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task complete_run;
    begin
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d);
    integer k;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 20) begin
        n_fail++;
        complete_run;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rdc(input [5:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      `CHK("register", e, q & m)
    end
  endtask
  task cmd(input [6:0] node, input [3:0] op, input [7:0] arg);
    begin
      bus(1'b1, 6'h18, {7'h00, blk, arg, 1'b0, node, 4'h0, op});
      repeat (3) @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      rdc(6'h04, 32'h7F, 32'h01);
      rdc(6'h08, 32'hFFFF, 32'h001E);
      rdc(6'h0C, 32'hFFFF, 32'h012C);
      rdc(6'h24, 32'hC0, 32'h00);
      rdc(6'h3C, 32'hFFFFFFFF, 32'h0);
      `CHK("field_on", 1'b1, exciter_field_on_r)
      `CHK("enables", 2'b11, {exciter_en_r, passive_en_r})
      `CHK("led", 1'b1, field_led_r)
    end
  endtask
  task t_cmd;
    begin
      cmd(7'h05, 4'h1, 8'h05);
      rdc(6'h18, 32'hFF, 32'hFF);
      cmd(7'h01, 4'h1, 8'h05);
      rdc(6'h18, 32'hFF, 32'h01);
      `CHK("segments", {7'h3F, 7'h6D}, {seg_tens_r, seg_ones_r})
      blk = 1'b1;
      cmd(7'h01, 4'h1, 8'hA5);
      blk = 1'b0;
      hi = 1'b0;
      lo = 1'b0;
      repeat (40) begin
        @(posedge clk);
        if ({seg_tens_r, seg_ones_r} === {7'h77, 7'h6D}) hi = 1'b1;
        if ({seg_tens_r, seg_ones_r} === 14'h0000) lo = 1'b1;
      end
      `CHK("disp_blink", 2'b11, {hi, lo})
      cmd(7'h01, 4'h5, 8'h00);
      `CHK("field_off", 1'b0, exciter_field_on_r)
      avs_byteenable <= 4'h7;
      cmd(7'h01, 4'h6, 8'h00);
      `CHK("part_be", 1'b0, exciter_field_on_r)
      avs_byteenable <= 4'hF;
      cmd(7'h01, 4'h6, 8'h00);
      `CHK("field_on", 1'b1, exciter_field_on_r)
      for (i = 0; i < 3; i++) begin
        cmd(7'h01, 4'h2 + i[3:0], 8'h00);
        `CHK("pwr_off", 3'b001 << i, pwr_off_r)
        rdc(6'h18, 32'h1FF, 32'h101);
        repeat (128) @(posedge clk);
        `CHK("pwr_hold", 3'b001 << i, pwr_off_r)
        j = 0;
        bus(1'b0, 6'h18, 32'h0);
        while (q[7:0] !== 8'h00 && j < 60) begin
          bus(1'b0, 6'h18, 32'h0);
          j++;
        end
        if (j == 60) begin
          n_fail++;
          complete_run;
        end
        `CHK("pwr_back", 3'b000, pwr_off_r)
      end
    end
  endtask
  task t_button;
    begin
      bus(1'b1, 6'h08, 32'h0004);
      i_pnl.press(0);
      rdc(6'h14, 32'h3, 32'h1);
      rdc(6'h24, 32'hC0, 32'h40);
      repeat (60) @(posedge clk);
      rdc(6'h24, 32'hC0, 32'hC0);
      i_pnl.press(1);
      rdc(6'h14, 32'h3, 32'h3);
      bus(1'b1, 6'h14, 32'h2);
      rdc(6'h14, 32'h3, 32'h2);
      cmd(7'h01, 4'h7, 8'h00);
      rdc(6'h14, 32'h3, 32'h0);
      `CHK("irq_masked", 1'b0, irq_r)
      bus(1'b1, 6'h20, 32'h1);
      @(posedge clk);
      `CHK("irq_raised", 1'b1, irq_r)
      bus(1'b1, 6'h1C, 32'h1);
      `CHK("irq_cleared", 1'b0, irq_r)
    end
  endtask
  task t_test;
    begin
      bus(1'b1, 6'h10, 32'h2);
      for (i = 0; i < 4; i++) begin
        if (i == 3) begin
          i_pnl.press(1);
          rdc(6'h10, 32'hFFFF, 32'h0202);
        end
        i_pnl.press(0);
        `CHK("code", {7'h3F, i == 1 ? 7'h06 : i == 2 ? 7'h5B : 7'h3F}, {seg_tens_r, seg_ones_r})
      end
      bus(1'b1, 6'h10, 32'h0);
    end
  endtask
  task t_motion;
    begin
      bus(1'b1, 6'h00, 32'h5);
      @(posedge clk);
      `CHK("gated_off", 3'b000, {exciter_en_r, passive_en_r, field_led_r})
      i_pnl.drive(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge clk);
      `CHK("motion_on", 3'b111, {exciter_en_r, passive_en_r, field_led_r})
      i_pnl.drive(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (48) @(posedge clk);
      `CHK("off_delay", 2'b11, {exciter_en_r, passive_en_r})
      repeat (52) @(posedge clk);
      `CHK("released", 3'b000, {exciter_en_r, passive_en_r, field_led_r})
      bus(1'b1, 6'h00, 32'h0);
      @(posedge clk);
      `CHK("ungated", 2'b11, {exciter_en_r, passive_en_r})
    end
  endtask
  task t_led;
    reg [3:0] cfg [0:4];
    begin
      cfg[0] = 4'h0;
      cfg[1] = 4'h2;
      cfg[2] = 4'hC;
      cfg[3] = 4'h6;
      cfg[4] = 4'hE;
      for (i = 0; i < 5; i++) begin
        bus(1'b1, 6'h00, {28'h0, cfg[i]});
        for (j = 0; j < 4; j++) begin
          i_pnl.drive(1'b0, j[1], j[0], 1'b0);
          repeat (8) @(posedge clk);
          `CHK("led", i == 0 | ((i == 1 | i == 3) & j[1]) | (i == 2 & j[0]) | (j == 3), field_led_r)
        end
      end
      i_pnl.drive(1'b0, 1'b1, 1'b1, 1'b1);
      hi = 1'b0;
      lo = 1'b0;
      repeat (40) begin
        @(posedge clk);
        if (field_led_r === 1'b1) hi = 1'b1;
        if (field_led_r === 1'b0) lo = 1'b1;
      end
      `CHK("blink", 2'b11, {hi, lo})
    end
  endtask
  task t_host_to;
    begin
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(6'h24, 32'hC0, 32'h00);
      repeat (4820) @(posedge clk);
      rdc(6'h24, 32'hC0, 32'hC0);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    blk = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_cmd;
    t_button;
    t_test;
    t_motion;
    t_led;
    t_host_to;
    complete_run;
  end
endmodule // tb_portal_panel_controller
bind psc_panel_ctrl psc_panel_ctrl_sva i_sva (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .motion_pin(motion_pin), .field_led_r(field_led_r),
  .exciter_en_r(exciter_en_r), .passive_en_r(passive_en_r), .pwr_off_r(pwr_off_r),
  .irq_r(irq_r));
